// ==== tio_debounce.sv ====
`timescale 1ns/1ns
`default_nettype none
module tio_debounce
  import tio_pkg::*;
#(
  parameter int STABLE_CYC = DEBOUNCE_CYC,
  parameter logic IDLE = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Pin and clean level
  input wire logic pin,
  output logic level_q
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(STABLE_CYC - 1);
  logic sync1_q, sync2_q;
  logic [CNT_W-1:0] cnt_q;
  wire differs = (sync2_q != level_q);

  // Two-flop synchroniser, first stage read only by the second
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= IDLE;
      sync2_q <= IDLE;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
    end
  end

  // Level follows only after it has held steady; bounce restarts count
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      level_q <= IDLE;
    end else if (!differs) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      level_q <= sync2_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  property p_debounce_hold;
    @(posedge clock) disable iff (!rst_b)
      $changed(level_q) |-> $past(cnt_q) == LAST && $past(differs);
  endproperty
  a_debounce_hold: assert property (p_debounce_hold)
    else $error("clean level changed before the input held steady");
endmodule : tio_debounce
`default_nettype wire

// ==== tio_io_control.sv ====
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Transmit/receive select high in transmit mode, low in receive.
// - Push-to-talk sense high means pressed, low means released.
// - Transmitter enable low while keyed, held high if timed out or channel busy.
// - Hanger input low is on-hook, high is off-hook.
// - Option switch low is pressed, high is released.
// - Expired time-out gives a continuous 1 kHz warning tone.
// - A beep gives a pulsing warning tone.
// - Each out-of-lock pulse drives the filter control high about 3 ms.
// - Filter control is low except during that pulse.
// - Mode input low means programming link attached; high means normal.
module tio_io_control
  import tio_pkg::*;
#(
  parameter int FILTER_CYC = FILTER_PULSE_CYC,
  parameter int TONE_CYC = TONE_HALF_CYC,
  parameter int GATE_CYC = BEEP_GATE_CYC,
  parameter int BOUNCE_CYC = DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic irq,
  // Front panel and microphone
  input wire logic ptt_sense,
  input wire logic hanger,
  input wire logic [OPT_W-1:0] option_sw_b,
  input wire logic remote_programming_link_b,
  // Synthesizer
  input wire logic lock_detect,
  output logic adaptive_filter,
  // Transmitter and audio
  output logic transmitter_key_enable_b,
  output logic tx_rx_select,
  output logic warning_tone
);
  // ****************************************************************
  // Constants at counter width
  // ****************************************************************
  localparam logic [CNT_W-1:0] FILTER_LAST = CNT_W'(FILTER_CYC - 1);
  localparam logic [CNT_W-1:0] TONE_LAST = CNT_W'(TONE_CYC - 1);
  localparam logic [CNT_W-1:0] GATE_LAST = CNT_W'(GATE_CYC - 1);

  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  logic ptt_level, hanger_level, mode_level;
  logic [OPT_W-1:0] option_level;
  logic lock_s1_q, lock_s2_q, lock_prev_q;

  tio_debounce #(.STABLE_CYC(BOUNCE_CYC), .IDLE(PTT_IDLE)) u_ptt (
    .clock(clock), .rst_b(rst_b), .pin(ptt_sense), .level_q(ptt_level));
  tio_debounce #(.STABLE_CYC(BOUNCE_CYC), .IDLE(HANGER_IDLE)) u_hanger (
    .clock(clock), .rst_b(rst_b), .pin(hanger), .level_q(hanger_level));
  tio_debounce #(.STABLE_CYC(BOUNCE_CYC), .IDLE(MODE_IDLE)) u_mode (
    .clock(clock), .rst_b(rst_b), .pin(remote_programming_link_b), .level_q(mode_level));

  // One debouncer per option switch
  genvar gi;
  generate
    for (gi = 0; gi < OPT_W; gi++) begin : g_opt
      tio_debounce #(.STABLE_CYC(BOUNCE_CYC), .IDLE(OPTION_IDLE)) u_opt (
        .clock(clock), .rst_b(rst_b), .pin(option_sw_b[gi]),
        .level_q(option_level[gi]));
    end
  endgenerate

  // Lock detect is not debounced: its square wave is the signal we want
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lock_s1_q <= LOCK_IDLE;
      lock_s2_q <= LOCK_IDLE;
      lock_prev_q <= LOCK_IDLE;
    end else begin
      lock_s1_q <= lock_detect;
      lock_s2_q <= lock_s1_q;
      lock_prev_q <= lock_s2_q;
    end
  end

  // Meaning of each conditioned level
  wire ptt_pressed = ptt_level;
  wire off_hook = hanger_level;
  wire [OPT_W-1:0] option_pressed = ~option_level;
  wire prog_mode = ~mode_level;
  wire lock_fall = lock_prev_q & ~lock_s2_q;

  // ****************************************************************
  // Control register and keying
  // ****************************************************************
  logic [DATA_W-1:0] ctrl_q;
  wire timeout_expired = ctrl_q[CTRL_TIMEOUT_BIT];
  wire busy_inhibit = ctrl_q[CTRL_BUSY_BIT];
  wire beep_on = ctrl_q[CTRL_BEEP_BIT];

  // No keying while the programming link owns the unit
  wire tx_mode = ptt_pressed & ~prog_mode;
  wire keyed = tx_mode & ~timeout_expired & ~busy_inhibit;
  logic tx_q, keyed_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_q <= 1'b0;
      keyed_q <= 1'b0;
    end else begin
      tx_q <= tx_mode;
      keyed_q <= keyed;
    end
  end

  assign tx_rx_select = tx_q;
  assign transmitter_key_enable_b = ~keyed_q;

  // ****************************************************************
  // Adaptive loop filter pulse
  // ****************************************************************
  logic [CNT_W-1:0] filt_cnt_q;
  logic filt_q;
  wire filt_busy = (filt_cnt_q != '0);

  // Each new edge restarts the full width, so a long unlock stays wide
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      filt_cnt_q <= '0;
      filt_q <= 1'b0;
    end else begin
      if (lock_fall) begin
        filt_cnt_q <= FILTER_LAST;
      end else if (filt_busy) begin
        filt_cnt_q <= filt_cnt_q - 1'b1;
      end
      filt_q <= lock_fall | filt_busy;
    end
  end

  assign adaptive_filter = filt_q;

  // ****************************************************************
  // Warning tone
  // ****************************************************************
  tio_tone_type tone_mode_q, tone_mode_d;
  logic [CNT_W-1:0] tone_cnt_q, gate_cnt_q;
  logic tone_sq_q, gate_sq_q, tone_out_q;

  // Steady tone outranks the beep
  always_comb begin
    tone_mode_d = TONE_OFF;
    if (timeout_expired) begin
      tone_mode_d = TONE_STEADY;
    end else if (beep_on) begin
      tone_mode_d = TONE_PULSE;
    end
  end

  // Square wave and beep gate; gate restarts so each beep opens whole
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tone_mode_q <= TONE_OFF;
      tone_cnt_q <= '0;
      gate_cnt_q <= '0;
      tone_sq_q <= 1'b0;
      gate_sq_q <= 1'b0;
    end else begin
      tone_mode_q <= tone_mode_d;
      tone_cnt_q <= (tone_cnt_q == TONE_LAST) ? '0 : tone_cnt_q + 1'b1;
      if (tone_cnt_q == TONE_LAST) begin
        tone_sq_q <= ~tone_sq_q;
      end
      if (tone_mode_q != TONE_PULSE) begin
        gate_cnt_q <= '0;
        gate_sq_q <= 1'b1;
      end else if (gate_cnt_q == GATE_LAST) begin
        gate_cnt_q <= '0;
        gate_sq_q <= ~gate_sq_q;
      end else begin
        gate_cnt_q <= gate_cnt_q + 1'b1;
      end
    end
  end

  // Output mux registered to keep the pin glitch free
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tone_out_q <= 1'b0;
    end else begin
      unique case (tone_mode_q)
        TONE_OFF: tone_out_q <= 1'b0;
        TONE_STEADY: tone_out_q <= tone_sq_q;
        TONE_PULSE: tone_out_q <= tone_sq_q & gate_sq_q;
        default: tone_out_q <= 1'b0;
      endcase
    end
  end

  assign warning_tone = tone_out_q;

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  logic ptt_prev_q, hook_prev_q, prog_prev_q;
  logic [OPT_W-1:0] opt_prev_q;
  logic [DATA_W-1:0] int_status_q, int_mask_q;
  logic [DATA_W-1:0] events;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ptt_prev_q <= PTT_IDLE;
      hook_prev_q <= HANGER_IDLE;
      prog_prev_q <= 1'b0;
      opt_prev_q <= '0;
    end else begin
      ptt_prev_q <= ptt_pressed;
      hook_prev_q <= off_hook;
      prog_prev_q <= prog_mode;
      opt_prev_q <= option_pressed;
    end
  end

  // A change of push-to-talk, hook or mode is an event; an option only on press, lock only on its falling edge
  always_comb begin
    events = '0;
    events[EV_PTT_BIT] = ptt_pressed ^ ptt_prev_q;
    events[EV_HOOK_BIT] = off_hook ^ hook_prev_q;
    events[EV_UNLOCK_BIT] = lock_fall;
    events[EV_PROG_BIT] = prog_mode ^ prog_prev_q;
    events[EV_OPTION_BIT] = |(option_pressed & ~opt_prev_q);
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  wire wr_ctrl = reg_wr & (reg_addr == ADDR_CTRL);
  wire wr_status = reg_wr & (reg_addr == ADDR_INT_STATUS);
  wire wr_mask = reg_wr & (reg_addr == ADDR_INT_MASK);
  wire [DATA_W-1:0] clear_bits = wr_status ? reg_wdata : '0;

  // Set beats a write-one clear in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
      int_mask_q <= INT_MASK_RESET;
      int_status_q <= INT_STATUS_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata;
      end
      if (wr_mask) begin
        int_mask_q <= reg_wdata;
      end
      int_status_q <= (int_status_q & ~clear_bits) | events;
    end
  end

  assign irq = |(int_status_q & int_mask_q);

  // Live state view
  logic [DATA_W-1:0] inputs_view;
  always_comb begin
    inputs_view = '0;
    inputs_view[IN_PTT_BIT] = ptt_pressed;
    inputs_view[IN_OFFHOOK_BIT] = off_hook;
    inputs_view[IN_PROG_BIT] = prog_mode;
    inputs_view[IN_LOCKED_BIT] = lock_s2_q;
    inputs_view[IN_FILTER_BIT] = filt_q;
    inputs_view[IN_TX_BIT] = tx_q;
    inputs_view[IN_KEYED_BIT] = keyed_q;
  end

  // Unmapped addresses read zero
  wire [DATA_W-1:0] rd_mux =
    (reg_addr == ADDR_CTRL) ? ctrl_q :
    (reg_addr == ADDR_INPUTS) ? inputs_view :
    (reg_addr == ADDR_OPTIONS) ? {{(DATA_W-OPT_W){1'b0}}, option_pressed} :
    (reg_addr == ADDR_INT_STATUS) ? int_status_q :
    (reg_addr == ADDR_INT_MASK) ? int_mask_q : '0;

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_txrx;
    @(posedge clock) disable iff (!rst_b)
      ##1 tx_rx_select == $past(ptt_pressed && !prog_mode);
  endproperty
  a_txrx: assert property (p_txrx)
    else $error("tx/rx select does not follow transmit mode");

  property p_ptt_keys;
    @(posedge clock) disable iff (!rst_b)
      $rose(ptt_level) && !prog_mode && ctrl_q[2:0] == 3'h0 |=> tx_rx_select;
  endproperty
  a_ptt_keys: assert property (p_ptt_keys)
    else $error("pressed push-to-talk did not select transmit");

  property p_key_inhibit;
    @(posedge clock) disable iff (!rst_b)
      (timeout_expired || busy_inhibit) |=> transmitter_key_enable_b;
  endproperty
  a_key_inhibit: assert property (p_key_inhibit)
    else $error("transmitter keyed while inhibited");

  property p_key_on;
    @(posedge clock) disable iff (!rst_b)
      tx_mode && !timeout_expired && !busy_inhibit |=> !transmitter_key_enable_b;
  endproperty
  a_key_on: assert property (p_key_on)
    else $error("transmitter not keyed while in transmit mode");

  property p_hook_status;
    @(posedge clock) disable iff (!rst_b)
      reg_rd && reg_addr == ADDR_INPUTS |=> reg_rdata[IN_OFFHOOK_BIT] == $past(hanger_level);
  endproperty
  a_hook_status: assert property (p_hook_status)
    else $error("off-hook status does not match hanger level");

  property p_option_status;
    @(posedge clock) disable iff (!rst_b)
      reg_rd && reg_addr == ADDR_OPTIONS |=> reg_rdata[OPT_W-1:0] == ~$past(option_level);
  endproperty
  a_option_status: assert property (p_option_status)
    else $error("option pressed status not inverted from level");

  property p_steady_tone;
    @(posedge clock) disable iff (!rst_b)
      tone_mode_q == TONE_STEADY && $changed(tone_sq_q) |=> warning_tone == $past(tone_sq_q);
  endproperty
  a_steady_tone: assert property (p_steady_tone)
    else $error("steady tone does not follow the 1 kHz square wave");

  property p_pulse_tone;
    @(posedge clock) disable iff (!rst_b)
      tone_mode_q == TONE_PULSE && !gate_sq_q |=> !warning_tone;
  endproperty
  a_pulse_tone: assert property (p_pulse_tone)
    else $error("beep tone sounds during its off gap");

  property p_filter_start;
    @(posedge clock) disable iff (!rst_b)
      lock_fall |=> adaptive_filter && filt_cnt_q == FILTER_LAST;
  endproperty
  a_filter_start: assert property (p_filter_start)
    else $error("filter pulse did not start at full width");

  property p_filter_end;
    @(posedge clock) disable iff (!rst_b)
      filt_cnt_q == '0 && !lock_fall |=> !adaptive_filter;
  endproperty
  a_filter_end: assert property (p_filter_end)
    else $error("filter control high outside its pulse");

  property p_filter_cause;
    @(posedge clock) disable iff (!rst_b)
      $rose(adaptive_filter) |-> $past(lock_fall);
  endproperty
  a_filter_cause: assert property (p_filter_cause)
    else $error("filter pulse without an out-of-lock edge");

  property p_prog_blocks;
    @(posedge clock) disable iff (!rst_b)
      prog_mode |=> !tx_rx_select && transmitter_key_enable_b;
  endproperty
  a_prog_blocks: assert property (p_prog_blocks)
    else $error("transmit while programming link attached");
endmodule : tio_io_control
`default_nettype wire

// ==== tio_io_control_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tio_io_control_tb_top;
  import tio_pkg::*;
  localparam int FC = 20;
  localparam int TC = 4;
  localparam int GC = 16;
  localparam int BC = 4;
  typedef struct packed {
    logic ptt; logic hook; logic prog; logic [3:0] opt; logic [2:0] ctrl;
    logic tx; logic key_b;
  } tio_row_type;
  logic clock, rst_b, reg_wr, reg_rd, irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val;
  logic ptt_sense, hanger, remote_programming_link_b, lock_detect;
  logic [3:0] option_sw_b, c_opt;
  logic adaptive_filter, transmitter_key_enable_b, tx_rx_select, warning_tone;
  logic c_ptt, c_hook, c_prog, c_unl;
  int error_cnt, total_checks, cyc, quiet, toggles, width;
  tio_row_type rows [5];

  tio_io_control #(.FILTER_CYC(FC), .TONE_CYC(TC), .GATE_CYC(GC), .BOUNCE_CYC(BC)) dut (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .ptt_sense(ptt_sense), .hanger(hanger), .option_sw_b(option_sw_b),
    .remote_programming_link_b(remote_programming_link_b), .lock_detect(lock_detect),
    .adaptive_filter(adaptive_filter), .transmitter_key_enable_b(transmitter_key_enable_b),
    .tx_rx_select(tx_rx_select), .warning_tone(warning_tone));

  tio_panel_model panel (
    .clock(clock), .press_ptt(c_ptt), .off_hook(c_hook), .press_opt(c_opt),
    .link_attached(c_prog), .unlocked(c_unl), .ptt_sense(ptt_sense), .hanger(hanger),
    .option_sw_b(option_sw_b), .remote_programming_link_b(remote_programming_link_b),
    .lock_detect(lock_detect));

  // ****************************************************************
  // Clock, watchdog and report
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Whole run is a few hundred cycles, so this only trips on a hang
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ****************************************************************
  // Register bus
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic settle();
    repeat (BC + 10) @(posedge clock);
    #1;
  endtask : settle

  // Tone activity over n cycles: toggles and longest unchanged run
  task automatic watch_tone(input int n);
    logic prev;
    int run;
    #1; // Step past the edge so the first sample is settled
    prev = warning_tone;
    run = 0;
    quiet = 0;
    toggles = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (warning_tone !== prev) toggles++;
      run = (warning_tone !== prev) ? 0 : run + 1;
      if (run > quiet) quiet = run;
      prev = warning_tone;
    end
  endtask : watch_tone

  // Let the loop slip for n cycles; the pulse is counted from its very start
  task automatic slip(input int n);
    c_unl <= 1'b1;
    width = 0;
    for (int k = 0; k < n + 100; k++) begin
      @(posedge clock);
      if (k == n - 1) c_unl <= 1'b0;
      #1;
      if (adaptive_filter === 1'b1) width++;
    end
  endtask : slip

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    {c_ptt, c_hook, c_prog, c_unl} = 4'h0;
    c_opt = 4'h0;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    rows[0] = {3'b110, 4'h0, 3'h0, 2'b10};
    rows[1] = {3'b100, 4'h5, 3'h1, 2'b11};
    rows[2] = {3'b110, 4'ha, 3'h2, 2'b11};
    rows[3] = {3'b101, 4'hf, 3'h0, 2'b01};
    rows[4] = {3'b010, 4'h0, 3'h0, 2'b01};
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    #1 chk({4'h0, tx_rx_select, transmitter_key_enable_b, adaptive_filter, irq}, 8'h04);
    rd(ADDR_CTRL, rd_val);
    chk(rd_val, CTRL_RESET);
    rd(ADDR_INT_MASK, rd_val);
    chk(rd_val, INT_MASK_RESET);
    rd(ADDR_INT_STATUS, rd_val);
    chk(rd_val, INT_STATUS_RESET);
    // Unmapped place reads zero and swallows writes
    wr(4'hf, 8'hff);
    rd(4'hf, rd_val);
    chk(rd_val, 8'h00);
    rd(ADDR_CTRL, rd_val);
    chk(rd_val, 8'h00);
    // Panel and control combinations
    foreach (rows[i]) begin
      c_ptt <= rows[i].ptt;
      c_hook <= rows[i].hook;
      c_prog <= rows[i].prog;
      c_opt <= rows[i].opt;
      wr(ADDR_CTRL, {5'h0, rows[i].ctrl});
      settle();
      chk({7'h0, tx_rx_select}, {7'h0, rows[i].tx});
      chk({7'h0, transmitter_key_enable_b}, {7'h0, rows[i].key_b});
      rd(ADDR_INPUTS, rd_val);
      chk(rd_val, {1'b0, ~rows[i].key_b, rows[i].tx, 2'b01, rows[i].prog, rows[i].hook,
                   rows[i].ptt});
      rd(ADDR_OPTIONS, rd_val);
      chk(rd_val, {4'h0, rows[i].opt});
    end
    // A short press is bounce and must not key
    wr(ADDR_INT_STATUS, 8'h1f);
    c_ptt <= 1'b1;
    repeat (2) @(posedge clock);
    c_ptt <= 1'b0;
    settle();
    chk({7'h0, tx_rx_select}, 8'h00);
    chk({7'h0, irq}, 8'h00);
    rd(ADDR_INT_STATUS, rd_val);
    chk(rd_val, 8'h00);
    // Unmasked event drives the interrupt, clear drops it
    wr(ADDR_INT_MASK, 8'h01);
    c_ptt <= 1'b1;
    settle();
    chk({7'h0, irq}, 8'h01);
    rd(ADDR_INT_STATUS, rd_val);
    chk(rd_val, 8'h01);
    wr(ADDR_INT_STATUS, 8'h01);
    #1 chk({7'h0, irq}, 8'h00);
    // Masked events stay sticky but quiet
    wr(ADDR_INT_MASK, 8'h00);
    c_ptt <= 1'b0;
    c_opt <= 4'h2;
    settle();
    chk({7'h0, irq}, 8'h00);
    rd(ADDR_INT_STATUS, rd_val);
    chk(rd_val, 8'h11);
    wr(ADDR_INT_STATUS, 8'h1f);
    // One slip, then a longer slip whose two out-of-lock edges six cycles apart stretch the pulse
    slip(6);
    chk(width[7:0], FC[7:0]);
    chk({7'h0, adaptive_filter}, 8'h00);
    slip(12);
    chk(width[7:0], 8'(FC + 6));
    rd(ADDR_INT_STATUS, rd_val);
    chk(rd_val, 8'h04);
    // Expired timer gives a steady square, beep a gated one
    wr(ADDR_CTRL, 8'h01);
    repeat (8) @(posedge clock);
    watch_tone(40);
    chk(toggles[7:0], 8'(40 / TC));
    chk(quiet[7:0], 8'(TC - 1));
    wr(ADDR_CTRL, 8'h04);
    watch_tone(4 * GC);
    chk({7'h0, quiet >= GC - TC && toggles > 0}, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    repeat (8) @(posedge clock);
    watch_tone(20);
    chk(toggles[7:0], 8'h00);
    // Reset in mid-run unkeys the transmitter and clears the registers
    c_ptt <= 1'b1;
    wr(ADDR_INT_MASK, 8'h01);
    settle();
    chk({7'h0, transmitter_key_enable_b}, 8'h00);
    chk({7'h0, irq}, 8'h01);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    #1 chk({4'h0, tx_rx_select, transmitter_key_enable_b, adaptive_filter, irq}, 8'h04);
    rd(ADDR_INT_MASK, rd_val);
    chk(rd_val, INT_MASK_RESET);
    // Held switch is taken again once the debouncer has run
    settle();
    chk({7'h0, tx_rx_select}, 8'h01);
    results();
  end
endmodule : tio_io_control_tb_top
`default_nettype wire

// ==== tio_panel_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module tio_panel_model #(
  parameter int HALF_CYC = 3
) (
  // Clock
  input wire logic clock,
  // Commands from the bench
  input wire logic press_ptt,
  input wire logic off_hook,
  input wire logic [3:0] press_opt,
  input wire logic link_attached,
  input wire logic unlocked,
  // Pins toward the block
  output var logic ptt_sense,
  output var logic hanger,
  output var logic [3:0] option_sw_b,
  output var logic remote_programming_link_b,
  output var logic lock_detect
);
  // Pins settle at the first edge, well inside the bench's reset
  int half_cnt;

  // Pins move just after the edge, like real contacts seen by a sampler
  always @(posedge clock) begin
    ptt_sense <= press_ptt;
    hanger <= off_hook;
    option_sw_b <= ~press_opt;
    remote_programming_link_b <= ~link_attached;
    // Square wave while out of lock, steady high otherwise
    if (!unlocked) begin
      lock_detect <= 1'b1;
      half_cnt <= 0;
    end else if (half_cnt == 0) begin
      lock_detect <= ~lock_detect;
      half_cnt <= HALF_CYC - 1;
    end else begin
      half_cnt <= half_cnt - 1;
    end
  end
endmodule : tio_panel_model
`default_nettype wire

// ==== tio_pkg.sv ====
`default_nettype none
package tio_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_KHZ = 10_000;
  localparam int FILTER_PULSE_US = 3_000;
  localparam int TONE_FREQ_HZ = 1_000;
  localparam int TONE_HALF_US = 1_000_000 / (2 * TONE_FREQ_HZ);
  localparam int BEEP_GATE_US = 50_000;
  localparam int DEBOUNCE_US = 5_000;
  // Least times round up to whole cycles
  localparam int FILTER_PULSE_CYC = (FILTER_PULSE_US * CLOCK_KHZ + 999) / 1000;
  localparam int TONE_HALF_CYC = (TONE_HALF_US * CLOCK_KHZ + 999) / 1000;
  localparam int BEEP_GATE_CYC = (BEEP_GATE_US * CLOCK_KHZ + 999) / 1000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_US * CLOCK_KHZ + 999) / 1000;
  localparam int CNT_W = 20;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_INPUTS = 4'h1;
  localparam logic [3:0] ADDR_OPTIONS = 4'h2;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h3;
  localparam logic [3:0] ADDR_INT_MASK = 4'h4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] INT_MASK_RESET = 8'h00;
  localparam logic [7:0] INT_STATUS_RESET = 8'h00;
  localparam int CTRL_TIMEOUT_BIT = 0;
  localparam int CTRL_BUSY_BIT = 1;
  localparam int CTRL_BEEP_BIT = 2;
  localparam int IN_PTT_BIT = 0;
  localparam int IN_OFFHOOK_BIT = 1;
  localparam int IN_PROG_BIT = 2;
  localparam int IN_LOCKED_BIT = 3;
  localparam int IN_FILTER_BIT = 4;
  localparam int IN_TX_BIT = 5;
  localparam int IN_KEYED_BIT = 6;
  localparam int EV_PTT_BIT = 0;
  localparam int EV_HOOK_BIT = 1;
  localparam int EV_UNLOCK_BIT = 2;
  localparam int EV_PROG_BIT = 3;
  localparam int EV_OPTION_BIT = 4;
  localparam int EV_W = 5;
  localparam int OPT_W = 4;

  // ****************************************************************
  // Pin idle levels
  // ****************************************************************
  localparam logic PTT_IDLE = 1'b0;
  localparam logic HANGER_IDLE = 1'b0;
  localparam logic OPTION_IDLE = 1'b1;
  localparam logic MODE_IDLE = 1'b1;
  localparam logic LOCK_IDLE = 1'b1;

  typedef enum logic [2:0] {
    TONE_OFF = 3'b001,
    TONE_STEADY = 3'b010,
    TONE_PULSE = 3'b100
  } tio_tone_type;
endpackage : tio_pkg
`default_nettype wire
